// file: rtl/acd_clock_chain.v
/*
  Clock generation chain of a delta-sigma converter: source select, input divider, modulator divider,
  oversampling ratio, serial clock output in synchronous master mode, and an AXI4-Lite register slave.
  Assumes the selected input clock runs below a quarter of clk, since both clock pins are sampled.
*/
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "acd_clock_chain_defines.vh"

module acd_clock_chain (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Clock pins.
  input wire crystal_clock_pin,
  input wire serial_clock_in,
  output reg serial_clock_out,
  output reg serial_clock_oe,
  // Derived clock enables.
  output reg internal_clock_pulse,
  output reg modulator_clock_pulse,
  output reg data_rate_pulse,
  // AXI4-Lite write address and data.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read.
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Decodes a byte address into a register selector; misaligned or unknown addresses select nothing.
  function [2:0] reg_sel;
    input [7:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        reg_sel = `ACD_SEL_NONE;
      end else if (addr[7:2] == `ACD_IDX_SRC_CFG) begin
        reg_sel = `ACD_SEL_SRC_CFG;
      end else if (addr[7:2] == `ACD_IDX_RATE_CFG) begin
        reg_sel = `ACD_SEL_RATE_CFG;
      end else if (addr[7:2] == `ACD_IDX_CTRL) begin
        reg_sel = `ACD_SEL_CTRL;
      end else if (addr[7:2] == `ACD_IDX_STATUS) begin
        reg_sel = `ACD_SEL_STATUS;
      end else begin
        reg_sel = `ACD_SEL_NONE;
      end
    end
  endfunction

  // Maps the oversampling code to the ratio minus one, the last value of the data-rate up-counter.
  function [11:0] ratio_last;
    input [3:0] code;
    begin
      case (code)
        4'h0: ratio_last = `ACD_RATIO_LAST_0;
        4'h1: ratio_last = `ACD_RATIO_LAST_1;
        4'h2: ratio_last = `ACD_RATIO_LAST_2;
        4'h3: ratio_last = `ACD_RATIO_LAST_3;
        4'h4: ratio_last = `ACD_RATIO_LAST_4;
        4'h5: ratio_last = `ACD_RATIO_LAST_5;
        4'h6: ratio_last = `ACD_RATIO_LAST_6;
        4'h7: ratio_last = `ACD_RATIO_LAST_7;
        4'h8: ratio_last = `ACD_RATIO_LAST_8;
        4'h9: ratio_last = `ACD_RATIO_LAST_9;
        4'hA: ratio_last = `ACD_RATIO_LAST_A;
        4'hB: ratio_last = `ACD_RATIO_LAST_B;
        4'hC: ratio_last = `ACD_RATIO_LAST_C;
        4'hD: ratio_last = `ACD_RATIO_LAST_D;
        4'hE: ratio_last = `ACD_RATIO_LAST_E;
        default: ratio_last = `ACD_RATIO_LAST_F;
      endcase
    end
  endfunction

  reg [7:0] src_cfg_q;
  reg [7:0] rate_cfg_q;
  reg [7:0] ctrl_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg xtal_s1_q;
  reg xtal_s2_q;
  reg sclk_s1_q;
  reg sclk_s2_q;
  reg src_prev_q;
  reg [2:0] in_cnt_q;
  reg intclk_level_q;
  reg [3:0] mod_cnt_q;
  reg [11:0] ratio_cnt_q;
  wire [2:0] in_div;
  wire [2:0] mod_div;
  wire cfg_error;
  wire src_level;
  wire src_rise;
  wire intclk_rise;
  wire [3:0] mod_last;
  wire [2:0] wsel;
  wire [2:0] rsel;
  reg [31:0] rd_word;

  assign in_div = src_cfg_q[`ACD_SRC_CFG_DIV_HI:`ACD_SRC_CFG_DIV_LO];
  assign mod_div = rate_cfg_q[`ACD_RATE_CFG_DIV_HI:`ACD_RATE_CFG_DIV_LO];
  // Reserved divider codes are unsupported; rather than guess a ratio, the chain stops.
  assign cfg_error = (in_div == `ACD_DIV_RESERVED) || (mod_div == `ACD_DIV_RESERVED);
  assign mod_last = {mod_div, 1'b0} - 4'h1;
  assign wsel = reg_sel(awaddr_q);
  assign rsel = reg_sel(s_axi_araddr);

  // Both clock pins pass two flip-flops; only the second stage feeds the source mux.
  always @(posedge clk) begin
    if (rst) begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
    end else begin
      xtal_s1_q <= crystal_clock_pin;
      xtal_s2_q <= xtal_s1_q;
      sclk_s1_q <= serial_clock_in;
      sclk_s2_q <= sclk_s1_q;
    end
  end

  // Source mux between crystal input and serial clock pin.
  assign src_level = src_cfg_q[`ACD_SRC_CFG_SEL_BIT] ? sclk_s2_q : xtal_s2_q;
  assign src_rise = src_level && !src_prev_q;
  // The internal clock rises once every 2N input rises, so its enable is the level's rising edge.
  // The compare matches the toggle below, so a code lowered mid-count still gives its pulse.
  assign intclk_rise = src_rise && !cfg_error && (in_cnt_q >= in_div - 3'h1) && !intclk_level_q;

  // Internal clock: the level toggles every N input rises, giving a period of 2N input periods.
  always @(posedge clk) begin
    if (rst) begin
      src_prev_q <= 1'b0;
      in_cnt_q <= 3'h0;
      intclk_level_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
      if (cfg_error) begin
        in_cnt_q <= 3'h0;
      end else if (src_rise) begin
        if (in_cnt_q >= in_div - 3'h1) begin
          in_cnt_q <= 3'h0;
          intclk_level_q <= !intclk_level_q;
        end else begin
          in_cnt_q <= in_cnt_q + 3'h1;
        end
      end
    end
  end

  // Modulator and data-rate counters, both advanced only by enable pulses of the stage before.
  always @(posedge clk) begin
    if (rst) begin
      mod_cnt_q <= 4'h0;
      ratio_cnt_q <= 12'h000;
      internal_clock_pulse <= 1'b0;
      modulator_clock_pulse <= 1'b0;
      data_rate_pulse <= 1'b0;
    end else begin
      internal_clock_pulse <= intclk_rise;
      modulator_clock_pulse <= 1'b0;
      data_rate_pulse <= 1'b0;
      if (cfg_error) begin
        mod_cnt_q <= 4'h0;
        ratio_cnt_q <= 12'h000;
      end else if (intclk_rise) begin
        if (mod_cnt_q >= mod_last) begin
          mod_cnt_q <= 4'h0;
          modulator_clock_pulse <= 1'b1;
          if (ratio_cnt_q >= ratio_last(rate_cfg_q[`ACD_RATE_CFG_RATIO_HI:`ACD_RATE_CFG_RATIO_LO])) begin
            ratio_cnt_q <= 12'h000;
            data_rate_pulse <= 1'b1;
          end else begin
            ratio_cnt_q <= ratio_cnt_q + 12'h001;
          end
        end else begin
          mod_cnt_q <= mod_cnt_q + 4'h1;
        end
      end
    end
  end

  // Serial clock output; the pin is released outside master mode so the host may drive it.
  always @(posedge clk) begin
    if (rst) begin
      serial_clock_out <= 1'b0;
      serial_clock_oe <= 1'b0;
    end else begin
      serial_clock_oe <= ctrl_q[`ACD_CTRL_MASTER_BIT];
      serial_clock_out <= ctrl_q[`ACD_CTRL_MASTER_BIT] & intclk_level_q;
    end
  end

  // Write channels are taken in either order; the response follows once both are held.
  always @(posedge clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACD_RESP_OKAY;
      src_cfg_q <= `ACD_SRC_CFG_RESET;
      rate_cfg_q <= `ACD_RATE_CFG_RESET;
      ctrl_q <= `ACD_CTRL_RESET;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == `ACD_SEL_NONE || wsel == `ACD_SEL_STATUS) ? `ACD_RESP_SLVERR : `ACD_RESP_OKAY;
        // Reserved bits are not stored, so a host that breaks the zero convention still reads zeros.
        if (wstrb_q[0]) begin
          case (wsel)
            `ACD_SEL_SRC_CFG: src_cfg_q <= wdata_q[7:0] & `ACD_SRC_CFG_WMASK;
            `ACD_SEL_RATE_CFG: rate_cfg_q <= wdata_q[7:0] & `ACD_RATE_CFG_WMASK;
            `ACD_SEL_CTRL: ctrl_q <= {7'h00, wdata_q[`ACD_CTRL_MASTER_BIT]};
            default: ctrl_q <= ctrl_q;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; the status word shows the halt flag, the internal clock level and the master enable.
  always @* begin
    rd_word = 32'h00000000;
    case (rsel)
      `ACD_SEL_SRC_CFG: rd_word = {24'h000000, src_cfg_q};
      `ACD_SEL_RATE_CFG: rd_word = {24'h000000, rate_cfg_q};
      `ACD_SEL_CTRL: rd_word = {24'h000000, ctrl_q};
      `ACD_SEL_STATUS: rd_word = {29'h00000000, ctrl_q[`ACD_CTRL_MASTER_BIT], intclk_level_q, cfg_error};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Read channel: the address is taken, then the data stands until rready.
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ACD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rsel == `ACD_SEL_NONE) ? `ACD_RESP_SLVERR : `ACD_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/acd_clock_chain_defines.vh
/*
  Constants of the converter clock chain: register indices, field positions, reset values and data-rate counter end values.
  Assumes it is included by its bare name from the clock chain module only.
*/
`ifndef ACD_CLOCK_CHAIN_DEFINES_VH
`define ACD_CLOCK_CHAIN_DEFINES_VH

// Register indices; the byte address is four times the index.
`define ACD_IDX_SRC_CFG 6'h0D
`define ACD_IDX_RATE_CFG 6'h0E
`define ACD_IDX_CTRL 6'h20
`define ACD_IDX_STATUS 6'h21

// Register selector codes.
`define ACD_SEL_NONE 3'h0
`define ACD_SEL_SRC_CFG 3'h1
`define ACD_SEL_RATE_CFG 3'h2
`define ACD_SEL_CTRL 3'h3
`define ACD_SEL_STATUS 3'h4

// Reset values.
`define ACD_SRC_CFG_RESET 8'h08
`define ACD_RATE_CFG_RESET 8'h86
`define ACD_CTRL_RESET 8'h00

// Field positions.
`define ACD_SRC_CFG_SEL_BIT 7
`define ACD_SRC_CFG_DIV_HI 3
`define ACD_SRC_CFG_DIV_LO 1
`define ACD_RATE_CFG_DIV_HI 7
`define ACD_RATE_CFG_DIV_LO 5
`define ACD_RATE_CFG_RATIO_HI 3
`define ACD_RATE_CFG_RATIO_LO 0
`define ACD_CTRL_MASTER_BIT 0

// Bits of the stored registers that software can change.
`define ACD_SRC_CFG_WMASK 8'h8E
`define ACD_RATE_CFG_WMASK 8'hEF

// Last count of the data-rate counter for each oversampling code: the ratio minus one.
`define ACD_RATIO_LAST_0 12'hFFF
`define ACD_RATIO_LAST_1 12'h7FF
`define ACD_RATIO_LAST_2 12'h3FF
`define ACD_RATIO_LAST_3 12'h31F
`define ACD_RATIO_LAST_4 12'h2FF
`define ACD_RATIO_LAST_5 12'h1FF
`define ACD_RATIO_LAST_6 12'h18F
`define ACD_RATIO_LAST_7 12'h17F
`define ACD_RATIO_LAST_8 12'h0FF
`define ACD_RATIO_LAST_9 12'h0C7
`define ACD_RATIO_LAST_A 12'h0BF
`define ACD_RATIO_LAST_B 12'h07F
`define ACD_RATIO_LAST_C 12'h05F
`define ACD_RATIO_LAST_D 12'h03F
`define ACD_RATIO_LAST_E 12'h02F
`define ACD_RATIO_LAST_F 12'h01F

// Reserved divider code.
`define ACD_DIV_RESERVED 3'h0

// AXI responses.
`define ACD_RESP_OKAY 2'h0
`define ACD_RESP_SLVERR 2'h2

`endif

// file: test/acd_clock_chain_props.sv
/* Port checker for the clock chain: enable nesting, pulse spacing, master clock quiet, bus handshakes.
   Assumes it is bound to the clock chain and that everything runs on the one clock. */
`timescale 1ns/100ps
module acd_clock_chain_props (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Clock outputs.
  input wire serial_clock_out,
  input wire serial_clock_oe,
  input wire internal_clock_pulse,
  input wire modulator_clock_pulse,
  input wire data_rate_pulse,
  // Bus handshakes.
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Slower enables only fire together with the next faster one.
  chk_mod_on_internal: assert property (modulator_clock_pulse |-> internal_clock_pulse)
    else $error("modulator pulse without internal pulse");
  chk_data_on_mod: assert property (data_rate_pulse |-> modulator_clock_pulse) else $error("data alone");
  // Pins are slower than clk/4, so a pulse is followed by quiet cycles.
  chk_internal_spacing: assert property (internal_clock_pulse |=> !internal_clock_pulse [*3])
    else $error("internal pulses too close");
  // Outside master mode the clock out stays low.
  chk_oe_quiet: assert property (!serial_clock_oe && !$past(serial_clock_oe) |-> !serial_clock_out)
    else $error("sclk out");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("bvalid late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata");
endmodule

// file: test/acd_clock_source.sv
/* Clock pin source: the crystal or the host serial clock.
   Assumes the half period is a multiple of 100 ns so edges stay clear of clk. */
`timescale 1ns/100ps
module acd_clock_source #(parameter HALF_NS = 400) (
  // Enable and pin.
  input wire run,
  output reg pin
);
  // Square wave while run is high, parked low otherwise like a stopped clock.
  initial begin
    pin = 1'b0;
    forever #HALF_NS pin = run ? ~pin : 1'b0;
  end
endmodule

// file: test/acd_clock_chain_tb.sv
/* Self-checking bench: register access, divider ratios, source select, master clock out, halt, reset.
   Assumes the checker and the clock source model are compiled before it. */
`timescale 1ns/100ps
module acd_clock_chain_tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} acd_row_t;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg use_sclk = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h00000000;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire crystal_clock_pin, host_sclk, serial_clock_out, serial_clock_oe, internal_clock_pulse;
  wire modulator_clock_pulse, data_rate_pulse, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  // The shared pin follows whoever drives it.
  wire serial_clock_in = serial_clock_oe ? serial_clock_out : host_sclk;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int i, g, ni, nm;
  logic [31:0] rd;
  logic [1:0] rs;
  reg s0;
  acd_row_t rows [0:6] = '{
    '{1'b0, 8'h38, 8'h00, 8'h86, 2'h0},
    '{1'b0, 8'h34, 8'h00, 8'h08, 2'h0},
    '{1'b1, 8'h34, 8'h02, 8'h02, 2'h0},
    '{1'b1, 8'h38, 8'h2F, 8'h2F, 2'h0},
    '{1'b1, 8'h40, 8'hFF, 8'h00, 2'h2},
    '{1'b1, 8'h35, 8'h01, 8'h00, 2'h2},
    '{1'b1, 8'h80, 8'h01, 8'h01, 2'h0}};
  acd_clock_chain dut (
    .clk(clk), .rst(rst), .crystal_clock_pin(crystal_clock_pin), .serial_clock_in(serial_clock_in),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .internal_clock_pulse(internal_clock_pulse), .modulator_clock_pulse(modulator_clock_pulse),
    .data_rate_pulse(data_rate_pulse),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  acd_clock_source #(.HALF_NS(400)) xtal (.run(1'b1), .pin(crystal_clock_pin));
  acd_clock_source #(.HALF_NS(600)) host (.run(use_sclk), .pin(host_sclk));
  // Clock generation.
  initial forever #50 clk = ~clk;
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (mismatches == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Address and data are offered together and each is dropped once taken.
  task axw(input [7:0] a, input [7:0] d, output [1:0] r);
    int n;
    begin
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (n < 2) begin
        @(posedge clk);
        n = n + (s_axi_awvalid & s_axi_awready) + (s_axi_wvalid & s_axi_wready);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) @(posedge clk);
      s_axi_bready <= 1'b1;
      @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  // Ready is raised late on purpose so the response must be held.
  task axr(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge clk);
      while (!s_axi_arready) @(posedge clk);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk);
      s_axi_rready <= 1'b1;
      @(posedge clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task gap(output int c);
    begin
      @(posedge clk);
      while (!internal_clock_pulse) @(posedge clk);
      c = 0;
      do begin @(posedge clk); c = c + 1; end while (!internal_clock_pulse);
    end
  endtask
  // Hang guard.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  // Main sequence: table rows, then the hand-written cases.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 7; i = i + 1) begin
      if (rows[i].wr) begin
        axw(rows[i].a, rows[i].d, rs);
        check("bresp", rs, rows[i].r);
      end
      axr(rows[i].a, rd, rs);
      check("rdata", rd, rows[i].e);
      check("rresp", rs, rows[i].r);
    end
    check("oe_on", serial_clock_oe, 1);
    s0 = serial_clock_out;
    repeat (8) @(posedge clk);
    check("sclk_toggle", s0 ^ serial_clock_out, 1);
    gap(g);
    check("gap_xtal", g, 16);
    while (!data_rate_pulse) @(posedge clk);
    ni = 0;
    nm = 0;
    do begin @(posedge clk); ni = ni + internal_clock_pulse; nm = nm + modulator_clock_pulse; end
    while (!data_rate_pulse);
    check("mod_per_data", nm, 32);
    check("internal_per_data", ni, 64);
    // A write with the low strobe clear is answered but leaves the register as it was.
    s_axi_wstrb <= 4'h0;
    axw(8'h38, 8'h00, rs);
    check("bresp_nostrb", rs, 2'h0);
    s_axi_wstrb <= 4'hF;
    axr(8'h38, rd, rs);
    check("rate_kept", rd, 32'h2F);
    axw(8'h80, 8'h00, rs);
    check("oe_off", serial_clock_oe, 0);
    check("sclk_off", serial_clock_out, 0);
    use_sclk <= 1'b1;
    axw(8'h34, 8'h82, rs);
    gap(g);
    gap(g);
    check("gap_sclk", g, 24);
    axw(8'h34, 8'h80, rs);
    axr(8'h84, rd, rs);
    check("halt_flag", rd[0], 1);
    ni = 0;
    repeat (100) begin @(posedge clk); ni = ni + internal_clock_pulse; end
    check("halted", ni, 0);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(8'h38, rd, rs);
    check("modulator_rate_config_reset", rd, 32'h86);
    check("oe_reset", serial_clock_oe, 0);
    check("sclk_reset", serial_clock_out, 0);
    axr(8'h34, rd, rs);
    check("src_reset", rd, 32'h08);
    tally_and_finish;
  end
endmodule
bind acd_clock_chain acd_clock_chain_props chk (
  .clk(clk), .rst(rst), .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
  .internal_clock_pulse(internal_clock_pulse), .modulator_clock_pulse(modulator_clock_pulse),
  .data_rate_pulse(data_rate_pulse), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
